// ### core/mtc_top.sv
// transmit control register and frame control logic of the mac
`default_nettype none
module mtc_top (
    input  wire logic        CLK_I,      // core clock, 100 MHz
    input  wire logic        RST_I,      // async reset, active high
    input  wire logic        CYC_I,      // wishbone cycle
    input  wire logic        STB_I,      // wishbone strobe
    input  wire logic        WE_I,       // wishbone write
    input  wire logic [7:0]  ADR_I,      // byte address
    input  wire logic [3:0]  SEL_I,      // byte lanes
    input  wire logic [31:0] DAT_I,      // write data
    output logic      [31:0] DAT_O,      // read data
    output logic             ACK_O,      // wishbone ack
    input  wire logic        FRAME_REQ_I,  // queue has a frame to send
    input  wire logic [15:0] FRAME_LEN_I,  // its length without fcs
    input  wire logic        FRAG_I,       // frame is ip fragment
    input  wire logic        IS_IP_I,      // frame carries ipv4
    input  wire logic        IS_TCP_I,     // frame carries tcp
    input  wire logic        IS_UDP_I,     // frame carries udp
    input  wire logic        IS_ICMP_I,    // frame carries icmp
    input  wire logic        FRAME_DONE_I, // datapath finished frame
    input  wire logic        FULL_DUPLEX_I, // phy resolved duplex pin
    input  wire logic        RX_NEAR_FULL_I, // rx buffer at threshold
    output logic             FRAME_START_O, // pulse: frame accepted
    output logic             BUSY_O,        // frame in progress
    output logic [15:0]      PAD_LEN_O,     // padded length of frame
    output logic             INS_IP_O,      // fill ip header checksum
    output logic             INS_TCP_O,     // fill tcp checksum
    output logic             INS_UDP_O,     // fill udp checksum
    output logic             INS_ICMP_O,    // fill icmp checksum
    output logic             APPEND_FCS_O,  // append crc32 trailer
    output logic             QUEUE_CLEAR_O, // clear tx queue memory
    output logic [12:0]      QUEUE_PTR_O,   // tx frame pointer
    output logic             PAUSE_REQ_O,   // pulse: send pause frame
    output logic             BACKPRESSURE_O // force collisions
);
    import mtc_pkg::*;

    // ************************************************************
    // registers and synchronisers
    // ************************************************************
    logic [15:0] ctl_q;        // transmit_control contents
    logic [1:0]  dup_sync_q;   // duplex pin synchroniser
    logic [1:0]  nf_sync_q;    // rx threshold synchroniser
    logic        near_full_d1_q; // previous synced threshold level
    mtc_state_e  state_q;      // transmitter state
    logic        req_hit;      // a bus request is present
    logic        wr_ctl;       // write to transmit_control

    assign req_hit = CYC_I && STB_I && !ACK_O;
    assign wr_ctl  = req_hit && WE_I && (ADR_I == TXCTL_OFFSET);

    // pad length helper, used at frame start
    function automatic logic [15:0] padded(input logic [15:0] len,
                                           input logic pad_on);
        padded = (pad_on && len < PAD_TARGET) ? PAD_TARGET : len;
    endfunction

    // start condition, shared by the option latch and the checks
    function automatic logic can_start(input mtc_state_e st,
                                       input logic [15:0] ctl,
                                       input logic req);
        can_start = (st == ST_IDLE) && ctl[RUN_BIT] && !ctl[FLUSH_BIT]
                    && req;
    endfunction

    // two flops on the pin-level phy and rx threshold inputs
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            dup_sync_q     <= 2'h0;
            nf_sync_q      <= 2'h0;
            near_full_d1_q <= 1'b0;
        end else begin
            dup_sync_q     <= {dup_sync_q[0], FULL_DUPLEX_I};
            nf_sync_q      <= {nf_sync_q[0], RX_NEAR_FULL_I};
            near_full_d1_q <= nf_sync_q[1];
        end
    end

    // ************************************************************
    // wishbone slave: one registered ack per request, one cycle after the strobe
    // ************************************************************
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ACK_O <= req_hit;
            DAT_O <= 32'h0000_0000;
            if (req_hit && !WE_I) begin
                // unmapped addresses read zero and still ack
                case (ADR_I)
                    TXCTL_OFFSET:  DAT_O <= {16'h0000, ctl_q};
                    TXSTAT_OFFSET: DAT_O <= {27'h0, dup_sync_q[1],
                                             BUSY_O, QUEUE_CLEAR_O,
                                             state_q};
                    default:       DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control register; upper bits are masked so they read zero
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctl_q <= TXCTL_RESET;
        end else if (wr_ctl) begin
            if (SEL_I[0]) begin
                ctl_q[7:0] <= DAT_I[7:0];
            end
            if (SEL_I[1]) begin
                ctl_q[15:8] <= DAT_I[15:8] & TXCTL_MASK[15:8];
            end
        end
    end

    // ************************************************************
    // transmitter state machine
    // ************************************************************
    // stop request is honoured only between frames, so a frame that
    // is on the wire always finishes with its fcs intact
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q       <= ST_STOPPED;
            FRAME_START_O <= 1'b0;
            BUSY_O        <= 1'b0;
        end else begin
            FRAME_START_O <= 1'b0;
            case (state_q)
                ST_STOPPED: begin
                    if (ctl_q[RUN_BIT] && !ctl_q[FLUSH_BIT]) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (!ctl_q[RUN_BIT] || ctl_q[FLUSH_BIT]) begin
                        state_q <= ST_STOPPED;
                    end else if (FRAME_REQ_I) begin
                        state_q       <= ST_BUSY;
                        FRAME_START_O <= 1'b1;
                        BUSY_O        <= 1'b1;
                    end
                end
                ST_BUSY: begin
                    if (FRAME_DONE_I) begin
                        BUSY_O  <= 1'b0;
                        // run cleared mid-frame takes effect here
                        state_q <= ctl_q[RUN_BIT] ? ST_IDLE
                                                  : ST_STOPPED;
                    end
                end
                default: begin
                    state_q <= ST_STOPPED;
                end
            endcase
        end
    end

    // per-frame options latched at start so they hold for the frame
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PAD_LEN_O    <= 16'h0000;
            INS_IP_O     <= 1'b0;
            INS_TCP_O    <= 1'b0;
            INS_UDP_O    <= 1'b0;
            INS_ICMP_O   <= 1'b0;
            APPEND_FCS_O <= 1'b0;
        end else if (can_start(state_q, ctl_q, FRAME_REQ_I)) begin
            PAD_LEN_O    <= padded(FRAME_LEN_I, ctl_q[PAD_BIT]);
            INS_IP_O     <= ctl_q[IPCS_BIT] && IS_IP_I;
            INS_TCP_O    <= ctl_q[TCPCS_BIT] && IS_TCP_I;
            INS_UDP_O    <= ctl_q[UDPCS_BIT] && IS_UDP_I;
            INS_ICMP_O   <= ctl_q[ICMPCS_BIT] && IS_ICMP_I
                            && !FRAG_I;
            APPEND_FCS_O <= ctl_q[FCS_BIT];
        end
    end

    // ************************************************************
    // queue flush
    // ************************************************************
    // flush is a level: the queue stays cleared as long as it is set
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            QUEUE_CLEAR_O <= 1'b0;
            QUEUE_PTR_O   <= QUEUE_PTR_RESET;
        end else begin
            QUEUE_CLEAR_O <= ctl_q[FLUSH_BIT];
            if (ctl_q[FLUSH_BIT]) begin
                QUEUE_PTR_O <= QUEUE_PTR_RESET;
            end else if (FRAME_DONE_I && state_q == ST_BUSY) begin
                QUEUE_PTR_O <= QUEUE_PTR_O + 13'(PAD_LEN_O);
            end
        end
    end

    // ************************************************************
    // flow control
    // ************************************************************
    // pause is sent once per rise of the threshold, not every cycle
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PAUSE_REQ_O    <= 1'b0;
            BACKPRESSURE_O <= 1'b0;
        end else begin
            PAUSE_REQ_O <= ctl_q[FLOW_BIT] && dup_sync_q[1] &&
                           nf_sync_q[1] && !near_full_d1_q;
            BACKPRESSURE_O <= ctl_q[FLOW_BIT] && !dup_sync_q[1] &&
                              nf_sync_q[1];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_ack_one;
        @(posedge CLK_I) disable iff (RST_I)
        ACK_O |=> !ACK_O;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");

    property p_resv_zero;
        @(posedge CLK_I) disable iff (RST_I)
        ctl_q[15:9] == 7'h00;
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("resv");

    property p_start;
        @(posedge CLK_I) disable iff (RST_I)
        FRAME_START_O |-> BUSY_O && state_q == ST_BUSY;
    endproperty
    a_start: assert property (p_start) else $error("bad start");

    sequence s_busy_norun;
        state_q == ST_BUSY && !FRAME_DONE_I;
    endsequence
    property p_no_abort;
        @(posedge CLK_I) disable iff (RST_I)
        s_busy_norun |=> state_q == ST_BUSY;
    endproperty
    a_no_abort: assert property (p_no_abort) else $error("abort");

    property p_flush;
        @(posedge CLK_I) disable iff (RST_I)
        ctl_q[FLUSH_BIT] |=> QUEUE_PTR_O == QUEUE_PTR_RESET
                             && QUEUE_CLEAR_O;
    endproperty
    a_flush: assert property (p_flush) else $error("flush");

    property p_pad;
        @(posedge CLK_I) disable iff (RST_I)
        FRAME_START_O && $past(ctl_q[PAD_BIT]) |-> PAD_LEN_O >= PAD_TARGET;
    endproperty
    a_pad: assert property (p_pad) else $error("short frame");

    property p_icmp;
        @(posedge CLK_I) disable iff (RST_I)
        FRAME_START_O && $past(FRAG_I) |-> !INS_ICMP_O;
    endproperty
    a_icmp: assert property (p_icmp) else $error("icmp frag");

    property p_noflow;
        @(posedge CLK_I) disable iff (RST_I)
        !ctl_q[FLOW_BIT] |=> !PAUSE_REQ_O && !BACKPRESSURE_O;
    endproperty
    a_noflow: assert property (p_noflow) else $error("flow off");

    property p_bp_half;
        @(posedge CLK_I) disable iff (RST_I)
        BACKPRESSURE_O |-> !PAUSE_REQ_O;
    endproperty
    a_bp_half: assert property (p_bp_half) else $error("both fc");

    property p_run;
        @(posedge CLK_I) disable iff (RST_I)
        state_q == ST_STOPPED && ctl_q[RUN_BIT] && !ctl_q[FLUSH_BIT]
        |=> state_q == ST_IDLE;
    endproperty
    a_run: assert property (p_run) else $error("no run");

    // ************************************************************
    // per-frame options, stop, pointer and flow control checks
    // ************************************************************
    // options are compared against the inputs seen at the accepting
    // edge, so a late change of a control bit cannot hide a fault
    property p_ip;
        @(posedge CLK_I) disable iff (RST_I)
        FRAME_START_O |-> INS_IP_O == ($past(ctl_q[IPCS_BIT])
                                       && $past(IS_IP_I));
    endproperty
    a_ip: assert property (p_ip) else $error("ip csum");

    property p_tcp;
        @(posedge CLK_I) disable iff (RST_I)
        FRAME_START_O |-> INS_TCP_O == ($past(ctl_q[TCPCS_BIT])
                                        && $past(IS_TCP_I));
    endproperty
    a_tcp: assert property (p_tcp) else $error("tcp csum");

    property p_udp;
        @(posedge CLK_I) disable iff (RST_I)
        FRAME_START_O |-> INS_UDP_O == ($past(ctl_q[UDPCS_BIT])
                                        && $past(IS_UDP_I));
    endproperty
    a_udp: assert property (p_udp) else $error("udp csum");

    property p_icmp_sel;
        @(posedge CLK_I) disable iff (RST_I)
        FRAME_START_O |-> INS_ICMP_O == ($past(ctl_q[ICMPCS_BIT])
                                         && $past(IS_ICMP_I)
                                         && !$past(FRAG_I));
    endproperty
    a_icmp_sel: assert property (p_icmp_sel) else $error("icmp csum");

    property p_fcs;
        @(posedge CLK_I) disable iff (RST_I)
        FRAME_START_O |-> APPEND_FCS_O == $past(ctl_q[FCS_BIT]);
    endproperty
    a_fcs: assert property (p_fcs) else $error("fcs");

    sequence s_accept;
        can_start(state_q, ctl_q, FRAME_REQ_I);
    endsequence
    property p_accept;
        @(posedge CLK_I) disable iff (RST_I)
        s_accept |=> FRAME_START_O && BUSY_O;
    endproperty
    a_accept: assert property (p_accept) else $error("no start");

    // the frame on the wire ends before the stop takes hold
    sequence s_last_beat;
        state_q == ST_BUSY && FRAME_DONE_I && !ctl_q[RUN_BIT];
    endsequence
    property p_stop;
        @(posedge CLK_I) disable iff (RST_I)
        s_last_beat |=> state_q == ST_STOPPED && !BUSY_O;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");

    // the pointer moves only when a frame ends or the queue flushes
    property p_ptr_hold;
        @(posedge CLK_I) disable iff (RST_I)
        !ctl_q[FLUSH_BIT] && !(FRAME_DONE_I && state_q == ST_BUSY)
        |=> $stable(QUEUE_PTR_O);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("ptr");

    sequence s_pause_due;
        ctl_q[FLOW_BIT] && dup_sync_q[1] && nf_sync_q[1] && !near_full_d1_q;
    endsequence
    property p_pause;
        @(posedge CLK_I) disable iff (RST_I)
        s_pause_due |=> PAUSE_REQ_O ##1 !PAUSE_REQ_O;
    endproperty
    a_pause: assert property (p_pause) else $error("pause");

    property p_bp_on;
        @(posedge CLK_I) disable iff (RST_I)
        ctl_q[FLOW_BIT] && !dup_sync_q[1] && nf_sync_q[1]
        |=> BACKPRESSURE_O;
    endproperty
    a_bp_on: assert property (p_bp_on) else $error("no bp");
endmodule
`default_nettype wire

// ### core/mtc_pkg.sv
// package of constants for the mac transmit control block
// Function
// - insert icmp checksum, unfragmented frames only
// - insert udp checksum when enabled
// - insert tcp checksum when enabled
// - insert ip header checksum when enabled
// - flush clears queue and resets frame pointer
// - full duplex flow control sends pause frames
// - half duplex flow control applies back-pressure
// - flow control off means no flow control
// - pad short frames up to 60 bytes, 64 with fcs
// - append 32-bit fcs when enabled
// - run bit starts the transmitter
// - stop only after current frame completes
`default_nettype none
package mtc_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  TXCTL_OFFSET   = 8'h70; // transmit_control
    localparam logic [7:0]  TXSTAT_OFFSET  = 8'h74; // state readback
    localparam logic [15:0] TXCTL_RESET    = 16'h0000;
    localparam logic [15:0] TXCTL_MASK     = 16'h01FF; // defined bits
    // ************************************************************
    // field positions of transmit_control
    // ************************************************************
    localparam int RUN_BIT   = 0; // transmitter_run
    localparam int FCS_BIT   = 1; // append_fcs_on
    localparam int PAD_BIT   = 2; // short_frame_padding_on
    localparam int FLOW_BIT  = 3; // transmit_flow_control_on
    localparam int FLUSH_BIT = 4; // flush_transmit_queue
    localparam int IPCS_BIT  = 5; // ip_header_checksum_insert
    localparam int TCPCS_BIT = 6; // tcp_checksum_insert
    localparam int UDPCS_BIT = 7; // udp_checksum_insert
    localparam int ICMPCS_BIT = 8; // icmp_checksum_insert
    // ************************************************************
    // frame sizes
    // ************************************************************
    localparam logic [15:0] MIN_FRAME_BYTES = 16'd64;
    localparam logic [15:0] FCS_BYTES       = 16'd4;
    localparam logic [15:0] PAD_TARGET      = 16'd60; // 64 minus fcs
    localparam logic [12:0] QUEUE_PTR_RESET = 13'h0000;
    typedef enum logic [1:0] {ST_STOPPED, ST_IDLE, ST_BUSY} mtc_state_e;
endpackage
`default_nettype wire

// ### sim/mtc_link_partner.sv
// link side model: reports each started frame as sent after a delay
`default_nettype none
module mtc_link_partner (
    input  wire logic       clk_i,   // core clock
    input  wire logic       rst_i,   // async reset, high
    input  wire logic       start_i, // pulse: frame accepted
    input  wire logic [7:0] delay_i, // wire time of a frame in cycles
    output logic            done_o   // pulse: frame fully sent
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] cnt_q; // cycles left on the wire, 0 when quiet
    // ****
    // frame timer
    // ****
    // a long delay lets the bench stop the transmitter mid-frame
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q  <= 9'h000;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_q == 9'h001);
            if (start_i) begin
                cnt_q <= {1'b0, delay_i} + 9'h001;
            end else if (cnt_q != 9'h000) begin
                cnt_q <= cnt_q - 9'h001;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/mtc_top_tb.sv
// self-checking bench for the transmit control block
`default_nettype none
module mtc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mtc_pkg::*;
    logic        clk, rst, cyc, we, ack, req, done, fd, rxf, start, busy;
    logic        frag, is_ip, is_tcp, is_udp, is_icmp, qclr, pause, bp;
    logic        ins_ip, ins_tcp, ins_udp, ins_icmp, fcs;
    logic [7:0]  adr, dly;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r, rd;
    logic [15:0] len, pad_len, ctl;
    logic [12:0] qptr, exp_ptr;
    logic [20:0] got_f;  // frame options as seen at start
    logic [20:0] fexp[$]; // expected options, oldest first
    int          bad_count, comparisons, npause;
    int          cyc_n = 0;
    assign got_f = {pad_len, ins_ip, ins_tcp, ins_udp, ins_icmp, fcs};
    mtc_top dut (
        .CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(cyc), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
        .ACK_O(ack), .FRAME_REQ_I(req), .FRAME_LEN_I(len),
        .FRAG_I(frag), .IS_IP_I(is_ip), .IS_TCP_I(is_tcp),
        .IS_UDP_I(is_udp), .IS_ICMP_I(is_icmp), .FRAME_DONE_I(done),
        .FULL_DUPLEX_I(fd), .RX_NEAR_FULL_I(rxf), .FRAME_START_O(start),
        .BUSY_O(busy), .PAD_LEN_O(pad_len), .INS_IP_O(ins_ip),
        .INS_TCP_O(ins_tcp), .INS_UDP_O(ins_udp), .INS_ICMP_O(ins_icmp),
        .APPEND_FCS_O(fcs), .QUEUE_CLEAR_O(qclr), .QUEUE_PTR_O(qptr),
        .PAUSE_REQ_O(pause), .BACKPRESSURE_O(bp));
    mtc_link_partner link (.clk_i(clk), .rst_i(rst), .start_i(start),
        .delay_i(dly), .done_o(done));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****
    // checking and verdict
    // ****
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_frame(input logic [20:0] g, input logic [20:0] e);
        cmp_reg({11'h000, g}, {11'h000, e});
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // a start with nothing noted is itself a fault
    always @(negedge clk) begin
        if (start === 1'b1 && fexp.size() == 0) begin
            cmp_reg(32'h1, 32'h0);
        end else if (start === 1'b1) begin
            cmp_frame(got_f, fexp.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            bad_count++;
            summarize();
        end
    end
    // ****
    // drivers
    // ****
    // classic cycle: hold until ack, release at the edge that saw it
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        sel   <= s;
        // no cycle count assumed: only the bench timeout ends a hang
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dat_r;
        cyc <= 1'b0;
    endtask
    task automatic wait_idle();
        do begin
            @(negedge clk);
        end while (busy !== 1'b0);
    endtask
    // a = frag, ip, tcp, udp, icmp; the expectation is noted first
    task automatic frame(input logic [15:0] l, input logic [4:0] a,
                         input bit wait_end);
        logic [15:0] p;
        p = (ctl[PAD_BIT] && l < PAD_TARGET) ? PAD_TARGET : l;
        fexp.push_back({p, ctl[IPCS_BIT] & a[3], ctl[TCPCS_BIT] & a[2],
            ctl[UDPCS_BIT] & a[1], ctl[ICMPCS_BIT] & a[0] & ~a[4],
            ctl[FCS_BIT]});
        exp_ptr += p[12:0];
        @(posedge clk);
        req <= 1'b1;
        len <= l;
        {frag, is_ip, is_tcp, is_udp, is_icmp} <= a;
        // hold the request until the edge that sees the start pulse
        do begin
            @(posedge clk);
        end while (start !== 1'b1);
        req <= 1'b0;
        if (wait_end) wait_idle();
    endtask
    task automatic wctl();
        wb(1'b1, TXCTL_OFFSET, {16'h0000, ctl}, 4'h3);
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        {rst, fd} = 2'b11;
        {cyc, we, req, rxf, frag, is_ip, is_tcp, is_udp, is_icmp} = '0;
        {adr, dat_w, len, ctl, exp_ptr} = '0;
        {sel, dly} = {4'h3, 8'h03};
        void'($urandom(32'h1412));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, TXCTL_OFFSET, 32'h0, 4'hF);
        cmp_reg(rd, {16'h0000, TXCTL_RESET});
        wb(1'b1, TXCTL_OFFSET, 32'hFFFF_FFFE, 4'h3);
        wb(1'b0, TXCTL_OFFSET, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0000_01FE);
        wb(1'b1, TXCTL_OFFSET, 32'h0, 4'h2);
        wb(1'b0, TXCTL_OFFSET, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0000_00FE);
        wb(1'b0, 8'h40, 32'h0, 4'hF);
        cmp_reg(rd, 32'h0);
        wb(1'b1, TXCTL_OFFSET, 32'h0, 4'h3);
        // run stays set, flush stays clear while frames go out
        for (int i = 0; i < 12; i++) begin
            ctl = 16'(($urandom & 32'h01EE) | 32'h1);
            if (i < 2) ctl[PAD_BIT] = 1'b1;
            if (ctl[PAD_BIT]) ctl[FCS_BIT] = 1'b1;
            wctl();
            dly <= 8'(1 + $urandom_range(6));
            frame(16'(i < 2 ? 59 + i : 40 + $urandom_range(40)),
                  5'($urandom), 1'b1);
        end
        dly <= 8'd40;
        frame(16'd100, 5'h0F, 1'b0);
        ctl[RUN_BIT] = 1'b0;
        wctl();
        cmp_reg({31'h0, busy}, 32'h1);
        wait_idle();
        wb(1'b0, TXSTAT_OFFSET, 32'h0, 4'hF);
        cmp_reg({30'h0, rd[1:0]}, 32'h0);
        @(posedge clk);
        req <= 1'b1;
        repeat (10) @(posedge clk);
        req <= 1'b0;
        cmp_reg({31'h0, busy}, 32'h0);
        cmp_reg({19'h0, qptr}, {19'h0, exp_ptr});
        ctl[FLUSH_BIT] = 1'b1;
        wctl();
        repeat (2) @(negedge clk);
        cmp_reg({18'h0, qclr, qptr}, {18'h0, 1'b1, QUEUE_PTR_RESET});
        ctl[FLUSH_BIT] = 1'b0;
        wctl();
        ctl = 16'h0007;
        exp_ptr = QUEUE_PTR_RESET;
        wctl();
        frame(16'd20, 5'h08, 1'b1);
        cmp_reg({19'h0, qptr}, {19'h0, exp_ptr});
        // full duplex pause, half duplex back-pressure, then none
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            fd <= (k == 0);
            rxf <= 1'b0;
            ctl[FLOW_BIT] = (k < 2);
            wctl();
            repeat (4) @(posedge clk);
            rxf <= 1'b1;
            npause = 0;
            repeat (8) begin
                @(negedge clk);
                npause += (pause === 1'b1);
            end
            cmp_reg(32'(npause), 32'(k == 0));
            cmp_reg({31'h0, bp}, 32'(k == 1));
        end
        summarize();
    end
endmodule
`default_nettype wire
